// ===== rtl/fmf_cell_if.sv
// Carriers between the fabric top and its input sections and macrocell banks
`timescale 1ns/1ps
`default_nettype none

// Input section carrier
interface fmf_in_if #(parameter int W = 10);
	import fmf_pkg::*;
	logic [W-1:0]  pin;       // Synchronised pin levels
	logic [W-1:0]  held;      // Section result to the array
	fmf_in_mode_e  mode;      // Block-wide form
	logic          cap_level; // Capture clock level
	logic          cap_pulse; // Capture clock rising edge
	modport sec (input pin, mode, cap_level, cap_pulse, output held);
	modport top (output pin, mode, cap_level, cap_pulse, input held);
endinterface

// Macrocell bank carrier
interface fmf_cell_if #(parameter int N = 10);
	import fmf_pkg::*;
	logic [N-1:0]  data_term;   // Data sum terms
	logic [N-1:0]  enable_term; // Enable sum terms
	logic [N-1:0]  data_pol;    // Data polarity bits
	logic [N-1:0]  enable_pol;  // Enable polarity bits
	fmf_mc_mode_e  mode [N];    // Per cell form
	logic          reset_term;  // Shared clear term
	logic          state_pulse; // State clock rising edge
	logic [N-1:0]  q;           // Cell results
	modport bank (input data_term, enable_term, data_pol, enable_pol, mode,
		reset_term, state_pulse, output q);
	modport top (output data_term, enable_term, data_pol, enable_pol, mode,
		reset_term, state_pulse, input q);
endinterface

`default_nettype wire

// ===== rtl/fmf_fabric.sv
// Top of the macrocell fabric: pins, input sections, cell banks, settings
// What this block does
// - Each input section uses one form for all its pins
// - Capture clock latches or clocks input sections
// - Two input sections configured independently
// - Eight hidden cells feed back only
// - Ten output cells drive pins and feed back
// - Each cell picks one of three forms
// - Own enable term drives each pin driver
// - Data polarity bit flips output cell data
// - Hidden cells offer true and inverted feedback
// - Each cell enable term has a polarity bit; pin driver enable terms have none
// - D/E form loads on state clock enable
// - Sum-term form clocks on enable term
// - One shared clear term resets all cell registers
// - Cleared register reads zero, pin one
// - Output cells feed back ahead of driver
// - Pin level returns through feedback section
// - Input and state clocks stay separate
`timescale 1ns/1ps
`default_nettype none
`include "fmf_regs.svh"

module fmf_fabric #(
	parameter int OUT_N = `FMF_OUT_CELLS,
	parameter int HID_N = `FMF_HID_CELLS,
	parameter int IN_N  = `FMF_IN_PINS
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic [`FMF_ADDR_W-1:0] reg_addr,
	input  wire logic [`FMF_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [`FMF_DATA_W-1:0] reg_rdata,
	input  wire logic                   input_capture_clock,
	input  wire logic                   state_register_clock,
	input  wire logic [IN_N-1:0]        dedicated_pin_in,
	input  wire logic [OUT_N-1:0]       io_pin_in,
	output logic      [OUT_N-1:0]       io_pin_out,
	output logic      [OUT_N-1:0]       io_pin_oe,
	input  wire logic [OUT_N-1:0]       out_data_term,
	input  wire logic [OUT_N-1:0]       out_enable_term,
	input  wire logic [OUT_N-1:0]       out_oe_term,
	input  wire logic [HID_N-1:0]       hid_data_term,
	input  wire logic [HID_N-1:0]       hid_enable_term,
	input  wire logic                   reset_term,
	output logic      [IN_N-1:0]        dedicated_fb,
	output logic      [OUT_N-1:0]       pin_fb,
	output logic      [OUT_N-1:0]       out_cell_fb,
	output logic      [HID_N-1:0]       hid_true_fb,
	output logic      [HID_N-1:0]       hid_inv_fb
);
	import fmf_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************

	// Pick the two-bit form field of cell i
	function automatic logic [`FMF_MODE_W-1:0] mode_at(
		input logic [`FMF_DATA_W-1:0] w,
		input int                     i
	);
		mode_at = w[i*`FMF_MODE_W +: `FMF_MODE_W];
	endfunction

	// Zero-extend a narrow field to a bus word
	function automatic logic [`FMF_DATA_W-1:0] widen(
		input logic [`FMF_DATA_W-1:0] v
	);
		widen = v;
	endfunction

	// ****************************************
	// Configuration registers
	// ****************************************

	logic [`FMF_DATA_W-1:0] in_mode_q;   // Both input section forms
	logic [`FMF_DATA_W-1:0] out_mode_q;  // Output cell forms
	logic [`FMF_DATA_W-1:0] hid_mode_q;  // Hidden cell forms
	logic [OUT_N-1:0]       data_pol_q;  // Output data polarity
	logic [OUT_N+HID_N-1:0] en_pol_q;    // Enable polarity, all cells
	logic [`FMF_DATA_W-1:0] rdata_q;     // Read answer

	// Writes of the settings words
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			in_mode_q  <= `FMF_CFG_RESET;
			out_mode_q <= `FMF_CFG_RESET;
			hid_mode_q <= `FMF_CFG_RESET;
			data_pol_q <= '0;
			en_pol_q   <= '0;
		end else if (reg_wr) begin
			if (reg_addr == `FMF_REG_IN_MODE) begin
				in_mode_q <= reg_wdata;
			end else if (reg_addr == `FMF_REG_OUT_MODE) begin
				out_mode_q <= reg_wdata;
			end else if (reg_addr == `FMF_REG_HID_MODE) begin
				hid_mode_q <= reg_wdata;
			end else if (reg_addr == `FMF_REG_DATA_POL) begin
				data_pol_q <= reg_wdata[OUT_N-1:0];
			end else if (reg_addr == `FMF_REG_EN_POL) begin
				en_pol_q <= reg_wdata[OUT_N+HID_N-1:0];
			end
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************

	logic [IN_N-1:0]  ded_s1_q;  // Dedicated pins, first stage
	logic [IN_N-1:0]  ded_s2_q;  // Dedicated pins, second stage
	logic [OUT_N-1:0] io_s1_q;   // I/O pins, first stage
	logic [OUT_N-1:0] io_s2_q;   // I/O pins, second stage
	logic [2:0]       icap_q;    // Capture clock: two stages and history
	logic [2:0]       sclk_q;    // State clock: two stages and history

	// Two flops on every pin before use
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ded_s1_q <= '0;
			ded_s2_q <= '0;
			io_s1_q  <= '0;
			io_s2_q  <= '0;
		end else begin
			ded_s1_q <= dedicated_pin_in;
			ded_s2_q <= ded_s1_q;
			io_s1_q  <= io_pin_in;
			io_s2_q  <= io_s1_q;
		end
	end

	// Clock pins sampled and edge history kept
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			icap_q <= '0;
			sclk_q <= '0;
		end else begin
			icap_q <= {icap_q[1:0], input_capture_clock};
			sclk_q <= {sclk_q[1:0], state_register_clock};
		end
	end

	logic icap_level; // Capture clock level
	logic icap_rise;  // Capture clock rising edge
	logic sclk_rise;  // State clock rising edge

	// Edge strobes from the second and third stages only
	always_comb begin
		icap_level = icap_q[1];
		icap_rise  = icap_q[1] & ~icap_q[2];
		sclk_rise  = sclk_q[1] & ~sclk_q[2];
	end

	// ****************************************
	// Input sections
	// ****************************************

	fmf_in_if #(.W(IN_N))  ded_if (); // Dedicated input cells
	fmf_in_if #(.W(OUT_N)) pfb_if (); // Pin feedback input cells

	// Section forms and capture clock hook-up
	always_comb begin
		ded_if.mode = fmf_in_mode_e'(in_mode_q[`FMF_DED_MODE_LSB +: `FMF_MODE_W]);
		pfb_if.mode = fmf_in_mode_e'(in_mode_q[`FMF_IO_MODE_LSB +: `FMF_MODE_W]);
		ded_if.pin       = ded_s2_q;
		ded_if.cap_level = icap_level;
		ded_if.cap_pulse = icap_rise;
		// pin level read back through section
		pfb_if.pin       = io_s2_q;
		pfb_if.cap_level = icap_level;
		pfb_if.cap_pulse = icap_rise;
	end

	// Dedicated input section
	fmf_input_section #(.W(IN_N)) u_dedicated_input_cell (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.sec      (ded_if)
	);

	// Pin feedback input section
	fmf_input_section #(.W(OUT_N)) u_pin_feedback_input_cell (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.sec      (pfb_if)
	);

	// ****************************************
	// Macrocell banks
	// ****************************************

	fmf_cell_if #(.N(OUT_N)) out_if (); // Pin output cells
	fmf_cell_if #(.N(HID_N)) hid_if (); // Hidden state cells

	// Output cell bank inputs
	always_comb begin
		// ten cells fed by the array
		out_if.data_term   = out_data_term;
		out_if.enable_term = out_enable_term;
		out_if.data_pol    = data_pol_q;
		out_if.enable_pol  = en_pol_q[OUT_N-1:0];
		out_if.reset_term  = reset_term;
		out_if.state_pulse = sclk_rise;
		for (int i = 0; i < OUT_N; i++) begin
			out_if.mode[i] = fmf_mc_mode_e'(mode_at(out_mode_q, i));
		end
	end

	// Hidden cell bank inputs
	always_comb begin
		// eight cells fed by the array
		hid_if.data_term   = hid_data_term;
		hid_if.enable_term = hid_enable_term;
		hid_if.data_pol    = '0;
		hid_if.enable_pol  = en_pol_q[OUT_N+HID_N-1:`FMF_EN_POL_HID_LSB];
		// same clear term as output cells
		hid_if.reset_term  = reset_term;
		hid_if.state_pulse = sclk_rise;
		for (int i = 0; i < HID_N; i++) begin
			hid_if.mode[i] = fmf_mc_mode_e'(mode_at(hid_mode_q, i));
		end
	end

	// Output cell bank
	fmf_macro_bank #(.N(OUT_N)) u_pin_output_cell (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.cb       (out_if)
	);

	// Hidden cell bank
	fmf_macro_bank #(.N(HID_N)) u_hidden_state_cell (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.cb       (hid_if)
	);

	// ****************************************
	// Pins and feedback to the array
	// ****************************************

	// Pin drivers and feedback paths
	always_comb begin
		io_pin_out   = ~out_if.q;
		// driver on by its own term
		io_pin_oe    = out_oe_term;
		out_cell_fb  = out_if.q;
		pin_fb       = pfb_if.held;
		dedicated_fb = ded_if.held;
		hid_true_fb  = hid_if.q;
		hid_inv_fb   = ~hid_if.q;
	end

	// ****************************************
	// Read port
	// ****************************************

	// Read data stand one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rdata_q <= `FMF_RDATA_IDLE;
		end else if (!reg_rd) begin
			rdata_q <= `FMF_RDATA_IDLE;
		end else if (reg_addr == `FMF_REG_IN_MODE) begin
			rdata_q <= in_mode_q;
		end else if (reg_addr == `FMF_REG_OUT_MODE) begin
			rdata_q <= out_mode_q;
		end else if (reg_addr == `FMF_REG_HID_MODE) begin
			rdata_q <= hid_mode_q;
		end else if (reg_addr == `FMF_REG_DATA_POL) begin
			rdata_q <= widen({{(`FMF_DATA_W-OUT_N){1'b0}}, data_pol_q});
		end else if (reg_addr == `FMF_REG_EN_POL) begin
			rdata_q <= widen({{(`FMF_DATA_W-OUT_N-HID_N){1'b0}}, en_pol_q});
		end else if (reg_addr == `FMF_REG_OUT_STATE) begin
			// Output cell results
			rdata_q <= widen({{(`FMF_DATA_W-OUT_N){1'b0}}, out_if.q});
		end else if (reg_addr == `FMF_REG_HID_STATE) begin
			// Hidden cell results
			rdata_q <= widen({{(`FMF_DATA_W-HID_N){1'b0}}, hid_if.q});
		end else if (reg_addr == `FMF_REG_IN_STATE) begin
			// Both input section results
			rdata_q <= widen({{(`FMF_DATA_W-OUT_N-IN_N){1'b0}}, pfb_if.held,
				ded_if.held});
		end else begin
			// Unmapped address reads zero
			rdata_q <= `FMF_RDATA_IDLE;
		end
	end

	// Read data from its flop
	always_comb begin
		reg_rdata = rdata_q;
	end

endmodule

`default_nettype wire

// ===== rtl/fmf_input_section.sv
// One block-configured input section: pass, latch or register
`timescale 1ns/1ps
`default_nettype none

module fmf_input_section #(
	parameter int W = 10
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	fmf_in_if.sec     sec
);
	import fmf_pkg::*;

	logic [W-1:0] store_q; // Latched or registered copy

	// Storage follows the section form
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			store_q <= '0;
		end else if (sec.mode == FMF_IN_LATCH && sec.cap_level) begin
			store_q <= sec.pin;
		end else if (sec.mode == FMF_IN_REG && sec.cap_pulse) begin
			store_q <= sec.pin;
		end
	end

	// Result chosen for the whole block
	always_comb begin
		case (sec.mode)
			FMF_IN_LATCH: sec.held = sec.cap_level ? sec.pin : store_q;
			FMF_IN_REG:   sec.held = store_q;
			default:      sec.held = sec.pin;
		endcase
	end

endmodule

`default_nettype wire

// ===== rtl/fmf_macro_bank.sv
// A bank of macrocells: combinatorial, sum-term clocked or D/E register
`timescale 1ns/1ps
`default_nettype none

module fmf_macro_bank #(
	parameter int N = 10
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	fmf_cell_if.bank  cb
);
	import fmf_pkg::*;

	logic [N-1:0] reg_q;   // Cell registers
	logic [N-1:0] e_prv_q; // Enable term of last cycle
	logic [N-1:0] d_term;  // Polarity adjusted data
	logic [N-1:0] e_term;  // Polarity adjusted enable
	logic [N-1:0] load;    // Register load strobes

	// Polarity and load decisions
	always_comb begin
		d_term = cb.data_term ^ cb.data_pol;
		e_term = cb.enable_term ^ cb.enable_pol;
		for (int i = 0; i < N; i++) begin
			case (cb.mode[i])
				// load on state clock when enabled
				FMF_MC_DE:     load[i] = cb.state_pulse & e_term[i];
				FMF_MC_SUMCLK: load[i] = e_term[i] & ~e_prv_q[i];
				default:       load[i] = 1'b0;
			endcase
		end
	end

	// Enable term history for edge finding
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			e_prv_q <= '0;
		end else begin
			e_prv_q <= e_term;
		end
	end

	// Cell registers with shared clear
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reg_q <= '0;
		end else if (cb.reset_term) begin
			reg_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (load[i]) begin
					reg_q[i] <= d_term[i];
				end
			end
		end
	end

	// Cell results
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (cb.mode[i] == FMF_MC_SUMCLK || cb.mode[i] == FMF_MC_DE) begin
				// cleared register reads zero at once
				cb.q[i] = cb.reset_term ? 1'b0 : reg_q[i];
			end else begin
				cb.q[i] = d_term[i];
			end
		end
	end

endmodule

`default_nettype wire

// ===== rtl/fmf_pkg.sv
// Mode types shared by the macrocell fabric modules
package fmf_pkg;

	// Input section forms
	typedef enum logic [1:0] {
		FMF_IN_PASS  = 2'b00,
		FMF_IN_LATCH = 2'b01,
		FMF_IN_REG   = 2'b10
	} fmf_in_mode_e;

	// Macrocell forms
	typedef enum logic [1:0] {
		FMF_MC_COMB   = 2'b00,
		FMF_MC_SUMCLK = 2'b01,
		FMF_MC_DE     = 2'b10
	} fmf_mc_mode_e;

endpackage

// ===== rtl/fmf_regs.svh
// Register offsets, field positions and reset values of the macrocell fabric
`ifndef FMF_REGS_SVH
`define FMF_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FMF_ADDR_W          8
`define FMF_DATA_W          32
`define FMF_REG_IN_MODE     8'h00
`define FMF_REG_OUT_MODE    8'h04
`define FMF_REG_HID_MODE    8'h08
`define FMF_REG_DATA_POL    8'h0c
`define FMF_REG_EN_POL      8'h10
`define FMF_REG_OUT_STATE   8'h14
`define FMF_REG_HID_STATE   8'h18
`define FMF_REG_IN_STATE    8'h1c

// ****************************************
// Field layout
// ****************************************
`define FMF_MODE_W          2
`define FMF_DED_MODE_LSB    0
`define FMF_IO_MODE_LSB     2
`define FMF_EN_POL_HID_LSB  10
`define FMF_IN_STATE_IO_LSB 10
`define FMF_OUT_CELLS       10
`define FMF_HID_CELLS       8
`define FMF_IN_PINS         10

// ****************************************
// Reset values
// ****************************************
`define FMF_CFG_RESET       32'h0000_0000
`define FMF_RDATA_IDLE      32'h0000_0000

`endif

// ===== sim/fmf_board_model.sv
// Board logic around the fabric pins
`timescale 1ns/1ps
`default_nettype none

module fmf_board_model #(
	parameter int IN_N  = 10,
	parameter int OUT_N = 10
) (
	input  wire logic [IN_N-1:0]  ded_level,
	input  wire logic [OUT_N-1:0] io_level,
	input  wire logic             io_drive_en,
	input  wire logic [OUT_N-1:0] io_pin_out,
	input  wire logic [OUT_N-1:0] io_pin_oe,
	output logic      [IN_N-1:0]  dedicated_pin_in,
	output logic      [OUT_N-1:0] io_pin_in
);
	// Dedicated pins are driven by the board
	assign dedicated_pin_in = ded_level;
	// Pin level resolved
	// Fabric driver wins, else board, else pull-up
	always_comb begin
		for (int i = 0; i < OUT_N; i++) begin
			if (io_pin_oe[i]) begin
				io_pin_in[i] = io_pin_out[i];
			end else if (io_drive_en) begin
				io_pin_in[i] = io_level[i];
			end else begin
				io_pin_in[i] = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/fmf_fabric_asserts.sv
// Port-level checker for the macrocell fabric top
`timescale 1ns/1ps
`default_nettype none
`include "fmf_regs.svh"

module fmf_fabric_asserts #(
	parameter int OUT_N = 10,
	parameter int HID_N = 8,
	parameter int IN_N  = 10
) (
	input wire logic                   core_clk,
	input wire logic                   rst_b,
	input wire logic [`FMF_ADDR_W-1:0] reg_addr,
	input wire logic                   reg_rd,
	input wire logic [`FMF_DATA_W-1:0] reg_rdata,
	input wire logic [OUT_N-1:0]       io_pin_out,
	input wire logic [OUT_N-1:0]       io_pin_oe,
	input wire logic [OUT_N-1:0]       out_oe_term,
	input wire logic                   reset_term,
	input wire logic [IN_N-1:0]        dedicated_fb,
	input wire logic [OUT_N-1:0]       pin_fb,
	input wire logic [OUT_N-1:0]       out_cell_fb,
	input wire logic [HID_N-1:0]       hid_true_fb,
	input wire logic [HID_N-1:0]       hid_inv_fb
);
	// ****************************************
	// Properties on the core clock
	// ****************************************
	default clocking cb_d @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Driver enable follows its own term
	property p_oe; io_pin_oe == out_oe_term; endproperty
	a_oe: assert property (p_oe) else $error("pin enable differs from term");
	// Pin shows inverted cell result
	property p_pin; io_pin_out == ~out_cell_fb; endproperty
	a_pin: assert property (p_pin) else $error("pin not inverted result");
	// Hidden pair is true and inverse
	property p_hid; hid_inv_fb == ~hid_true_fb; endproperty
	a_hid: assert property (p_hid) else $error("hidden pair mismatch");
	// Clear term forces results low
	property p_clr; reset_term |-> out_cell_fb == '0 && hid_true_fb == '0; endproperty
	a_clr: assert property (p_clr) else $error("clear term ignored");
	// Read data idle outside read answer
	property p_idle; !$past(reg_rd) |-> reg_rdata == '0; endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	// Output results readable before driver
	property p_rd_out;
		reg_rd && reg_addr == `FMF_REG_OUT_STATE |=> reg_rdata == 32'($past(out_cell_fb));
	endproperty
	a_rd_out: assert property (p_rd_out) else $error("output state read wrong");
	// Hidden results readable
	property p_rd_hid;
		reg_rd && reg_addr == `FMF_REG_HID_STATE |=> reg_rdata == 32'($past(hid_true_fb));
	endproperty
	a_rd_hid: assert property (p_rd_hid) else $error("hidden state read wrong");
	// Both input section results readable
	property p_rd_in;
		reg_rd && reg_addr == `FMF_REG_IN_STATE
			|=> reg_rdata == 32'({$past(pin_fb), $past(dedicated_fb)});
	endproperty
	a_rd_in: assert property (p_rd_in) else $error("input state read wrong");
	// Unmapped read answers zero
	property p_rd_gap; reg_rd && reg_addr == 8'h20 |=> reg_rdata == '0; endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
endmodule

bind fmf_fabric fmf_fabric_asserts #(.OUT_N(OUT_N), .HID_N(HID_N), .IN_N(IN_N))
	fmf_fabric_asserts_i (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_pin_out(io_pin_out),
	.io_pin_oe(io_pin_oe), .out_oe_term(out_oe_term), .reset_term(reset_term),
	.dedicated_fb(dedicated_fb), .pin_fb(pin_fb), .out_cell_fb(out_cell_fb),
	.hid_true_fb(hid_true_fb), .hid_inv_fb(hid_inv_fb));
`default_nettype wire

// ===== sim/fmf_fabric_tb.sv
// Self-checking bench of the macrocell fabric
`timescale 1ns/1ps
`default_nettype none

module fmf_fabric_tb;
	import fmf_pkg::*;
	logic        core_clk, rst_b, reg_wr, reg_rd, io_drive_en;
	logic        input_capture_clock, state_register_clock, reset_term;
	logic [7:0]  reg_addr, hid_data_term, hid_enable_term, hid_true_fb, hid_inv_fb;
	logic [31:0] reg_wdata, reg_rdata;
	logic [9:0]  io_pin_out, io_pin_oe, out_data_term, out_enable_term, out_oe_term;
	logic [9:0]  dedicated_pin_in, io_pin_in, dedicated_fb, pin_fb, out_cell_fb;
	logic [9:0]  ded_level, io_level;
	logic [31:0] cfg [5] = '{32'h9, 32'h96a59, 32'h6a59, 32'h155, 32'h2a9aa};
	int          err_total = 0;
	int          num_checks = 0;

	fmf_fabric fmf_fabric_i (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.input_capture_clock(input_capture_clock),
		.state_register_clock(state_register_clock), .dedicated_pin_in(dedicated_pin_in),
		.io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
		.out_data_term(out_data_term), .out_enable_term(out_enable_term),
		.out_oe_term(out_oe_term), .hid_data_term(hid_data_term),
		.hid_enable_term(hid_enable_term), .reset_term(reset_term),
		.dedicated_fb(dedicated_fb), .pin_fb(pin_fb), .out_cell_fb(out_cell_fb),
		.hid_true_fb(hid_true_fb), .hid_inv_fb(hid_inv_fb));
	fmf_board_model fmf_board_model_i (.ded_level(ded_level), .io_level(io_level),
		.io_drive_en(io_drive_en), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
		.dedicated_pin_in(dedicated_pin_in), .io_pin_in(io_pin_in));

	// ****************************************
	// Tasks
	// ****************************************
	// Compare one value
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Wait whole cycles
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle read, data checked in the following cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), exp, reg_rdata);
	endtask
	// Pulse clear term, check results held low after it
	task automatic clr;
		@(posedge core_clk);
		reset_term <= 1'b1;
		@(posedge core_clk);
		#1;
		chk("clr out", 0, out_cell_fb);
		chk("clr pin", 10'h3ff, io_pin_out);
		@(posedge core_clk);
		reset_term <= 1'b0;
		#1;
		chk("clr hold", 0, out_cell_fb);
	endtask
	// State clock pulse, long enough to pass the syncs
	task automatic sclk;
		@(posedge core_clk);
		state_register_clock <= 1'b1;
		cyc(4);
		state_register_clock <= 1'b0;
		cyc(4);
		#1;
	endtask
	// Counts and verdict
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and tests
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Hang guard
	initial begin
		#20000;
		err_total++;
		end_sim;
	end
	initial begin
		{rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, reset_term} = '0;
		{input_capture_clock, state_register_clock, io_drive_en} = '0;
		{out_data_term, out_enable_term, out_oe_term, ded_level, io_level} = '0;
		{hid_data_term, hid_enable_term} = '0;
		cyc(3);
		rst_b <= 1'b1;
		// Reset values, readback, unmapped and read-only places
		for (int a = 0; a <= 16; a += 4) rd(8'(a), 0);
		rd(8'h20, 0);
		for (int i = 0; i < 5; i++) begin
			wr(8'(4 * i), cfg[i]);
			rd(8'(4 * i), cfg[i]);
		end
		for (int i = 0; i < 5; i++) wr(8'(4 * i), 0);
		wr(8'h14, 32'hffffffff);
		rd(8'h14, 0);
		$display("registers done");
		// Combinatorial cells and data polarity
		@(posedge core_clk);
		out_data_term <= 10'h155;
		hid_data_term <= 8'h5a;
		#1;
		chk("comb out", 10'h155, out_cell_fb);
		chk("comb hid", 8'h5a, hid_true_fb);
		wr(8'h0c, 32'h3ff);
		#1;
		chk("pol out", 10'h2aa, out_cell_fb);
		rd(8'h14, 32'h2aa);
		$display("comb done");
		// D/E cells on state clock with enable polarity
		wr(8'h0c, 0);
		wr(8'h04, 32'haaaaa);
		wr(8'h08, 32'haaaa);
		clr;
		out_data_term <= 10'h3ff;
		out_enable_term <= 10'h0f0;
		hid_data_term <= 8'hff;
		hid_enable_term <= 8'h0f;
		cyc(4);
		chk("de wait", 0, out_cell_fb);
		sclk;
		chk("de out", 10'h0f0, out_cell_fb);
		chk("de hid", 8'h0f, hid_true_fb);
		wr(8'h10, 32'h3ffff);
		sclk;
		chk("epol out", 10'h3ff, out_cell_fb);
		chk("epol hid", 8'hff, hid_true_fb);
		clr;
		$display("de done");
		// Sum-term clocked cells
		wr(8'h10, 0);
		wr(8'h04, 32'h55555);
		wr(8'h08, 32'h5555);
		out_enable_term <= 0;
		hid_enable_term <= 0;
		out_data_term <= 10'h2aa;
		hid_data_term <= 8'h55;
		clr;
		cyc(2);
		out_enable_term <= 10'h3ff;
		hid_enable_term <= 8'hff;
		cyc(3);
		#1;
		chk("st out", 10'h2aa, out_cell_fb);
		chk("st hid", 8'h55, hid_true_fb);
		out_data_term <= 0;
		sclk;
		chk("st hold", 10'h2aa, out_cell_fb);
		$display("sum-term done");
		// Input sections: pass, then latched beside registered
		wr(8'h04, 0);
		wr(8'h08, 0);
		ded_level <= 10'h123;
		io_level <= 10'h0ab;
		io_drive_en <= 1'b1;
		cyc(4);
		#1;
		chk("pass ded", 10'h123, dedicated_fb);
		chk("pass io", 10'h0ab, pin_fb);
		wr(8'h00, 32'h9);
		input_capture_clock <= 1'b1;
		cyc(4);
		ded_level <= 10'h0cc;
		io_level <= 10'h311;
		cyc(4);
		#1;
		chk("latch open", 10'h0cc, dedicated_fb);
		chk("reg held", 10'h0ab, pin_fb);
		input_capture_clock <= 1'b0;
		cyc(4);
		ded_level <= 10'h055;
		cyc(4);
		#1;
		chk("latch shut", 10'h0cc, dedicated_fb);
		rd(8'h1c, 32'h2accc);
		input_capture_clock <= 1'b1;
		cyc(4);
		#1;
		chk("reg edge", 10'h311, pin_fb);
		input_capture_clock <= 1'b0;
		$display("inputs done");
		// Pin driven by fabric, then released to pull-up
		wr(8'h00, 0);
		io_drive_en <= 1'b0;
		out_oe_term <= 10'h3ff;
		out_data_term <= 10'h0f0;
		cyc(4);
		#1;
		chk("oe on", 10'h3ff, io_pin_oe);
		chk("pin back", 10'h30f, pin_fb);
		out_oe_term <= 0;
		cyc(4);
		#1;
		chk("pin free", 10'h3ff, pin_fb);
		chk("fb kept", 10'h0f0, out_cell_fb);
		$display("pins done");
		end_sim;
	end
endmodule
`default_nettype wire
